// *** rtl/dwi_defs.vh ***
// Offsets, field positions, reset values and timing counts
`ifndef DWI_DEFS_VH
`define DWI_DEFS_VH
// Register offsets
`define DWI_OFS_WARN        8'hcb
`define DWI_OFS_THYR        8'hcc
`define DWI_OFS_ILK         8'hcd
// Warning bits
`define DWI_WRN_SHORT       0
`define DWI_WRN_SYNC        3
`define DWI_WRN_ILIM        4
`define DWI_WRN_IDENT       5
`define DWI_WRN_FLDOC       6
`define DWI_WRN_AIR         12
`define DWI_WRN_RAIL        13
`define DWI_COMM_CLOCK_DESYNC_FLAG         14
`define DWI_WRN_LINK        15
// Interlock bits
`define DWI_ILK_CONFLICT    0
`define DWI_ILK_PARAMS      1
`define DWI_ILK_GAINS       2
`define DWI_ILK_FAULTS      3
`define DWI_ILK_PERMIT      4
`define DWI_ILK_FNR         5
`define DWI_ILK_FNA         6
// Drive control fields
`define DWI_CTL_ALPHA       0
`define DWI_CTL_IDENT       1
`define DWI_CTL_RUN         2
`define DWI_CTL_FIELD       4
`define DWI_CTL_FLT_RESET   8
`define DWI_CTL_WRN_RESET   9
// Reset values
`define DWI_RST_WORD        16'h0000
// Timing: field overcurrent hold time
`define DWI_CLK_HZ          20000000
`define DWI_FLDOC_MS        1000
`define DWI_FLDOC_CYC       ((`DWI_CLK_HZ / 1000) * `DWI_FLDOC_MS)
`endif

// *** rtl/dwi_persist.v ***
// Persistence timer: condition held for a set number of cycles
`timescale 1ns/10ps
module dwi_persist #(
	parameter HOLD_CYC = 20000000
) (
	input  wire clock,
	input  wire rst_n,
	input  wire cond,
	output reg  held
);
	reg [24:0] count_reg;

	always @(posedge clock) begin
		if (!rst_n) begin
			count_reg <= 25'h0000000;
			held      <= 1'b0;
		end else if (!cond) begin
			count_reg <= 25'h0000000;
			held      <= 1'b0;
		end else if (count_reg >= HOLD_CYC[24:0] - 25'h0000001) begin
			held <= 1'b1;
		end else begin
			count_reg <= count_reg + 25'h0000001;
		end
	end
endmodule // dwi_persist

// *** rtl/dwi_status.v ***
// Drive warning, thyristor diagnostic and run interlock status registers
`timescale 1ns/10ps
`include "dwi_defs.vh"
// Summary of operation
// - Set warning bit 3 when running through temporary AC line loss.
// - Set warning bit 4 when current reference exceeds the max limit.
// - Set warning bit 5 on identification or resolver balance test failure.
// - Set warning bit 6 when field current over 1.5x hot amps for 1 s.
// - Set warning bit 12 when rack airflow is not sensed.
// - Set warning bit 13 on a logged rail communication problem.
// - Set warning bit 14 when comm clock counters lose sync.
// - Set warning bit 15 on a fiber link communication error.
// - Two consecutive bad link messages raise a drive fault.
// - Shorted thyristor test on run turn-on; bad firing sets warning bit 0.
// - Fault reset or warning reset clears the thyristor diagnostic register.
// - Regenerative drive reports thyristor pair, otherwise single thyristor.
// - Forward thyristors 1-6 on bits 0-5, reverse 11-16 on 6-11.
// - Interlock checks run when command bits 0-7 set; first problem only.
// - Interlocks latch until warning reset set then cleared; block loops.
// - Interlock bit 0 on conflicting armature requests or task not running.
// - Commands edge-sensitive; restart without clearing sets interlock bit 0.
// - Interlock bit 1 when armature parameters are not downloaded.
// - Interlock bit 2 when armature gains are zero.
// - Interlock bit 3 when earlier armature faults are not cleared.
// - Interlock bit 4 when run permissive input is off.
// - Interlock bit 5 if field not on; bit 6 if field during tests.
// - Warning bits latch until warning reset is set then cleared.
module dwi_status #(
	// Hold count exposed; one second is far too long to simulate
	parameter FLDOC_CYC = `DWI_FLDOC_CYC
) (
	input  wire        clock,
	input  wire        rst_n,
	input  wire [15:0] drive_control,
	input  wire        sync_loss_ridden,
	input  wire        current_ref_over_limit,
	input  wire        ident_test_failed,
	input  wire        resolver_cal_failed,
	input  wire        field_over_1p5_hot,
	input  wire        airflow_missing,
	input  wire        rail_error_logged,
	input  wire        comm_clock_counter_slip,
	input  wire        link_msg_done,
	input  wire        link_msg_error,
	input  wire        shorted_test_done,
	input  wire        shorted_test_bad,
	input  wire [11:0] shorted_test_map,
	input  wire        regen_drive,
	input  wire        task_running,
	input  wire        arm_params_loaded,
	input  wire        arm_gains_zero,
	input  wire        arm_faults_pending,
	input  wire        run_permissive,
	input  wire        field_on,
	input  wire        test_running,
	input  wire [7:0]  reg_addr,
	input  wire        reg_rd,
	input  wire        reg_wr,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata,
	output reg         reg_hit,
	output reg  [15:0] drive_warning_flags,
	output reg  [15:0] thyristor_diagnostic_flags,
	output reg  [15:0] run_interlock_flags,
	output reg         link_comm_fault,
	output reg         shorted_test_start,
	output reg         current_loop_enable,
	output reg         field_loop_enable
);
	// ------------------------------------------------------------
	// Command edges and resets
	// ------------------------------------------------------------
	reg  [15:0] ctl_prev_reg;
	reg         link_err_prev_reg;
	reg  [7:0]  armed_reg;
	reg  [15:0] ilk_next;
	reg  [15:0] thyr_map;
	wire        fld_held;
	wire [7:0]  cmd_rise;
	wire        wrn_reset_fall;
	wire        flt_reset_on;
	wire        wrn_reset_on;
	wire        alpha_req;
	wire        ident_req;
	wire        run_req;
	wire        field_req;
	wire [15:0] wrn_set;
	integer     i;

	assign cmd_rise = drive_control[7:0] & ~ctl_prev_reg[7:0];
	assign wrn_reset_fall = ctl_prev_reg[`DWI_CTL_WRN_RESET] &
		~drive_control[`DWI_CTL_WRN_RESET];
	assign flt_reset_on = drive_control[`DWI_CTL_FLT_RESET] &
		~ctl_prev_reg[`DWI_CTL_FLT_RESET];
	assign wrn_reset_on = drive_control[`DWI_CTL_WRN_RESET] &
		~ctl_prev_reg[`DWI_CTL_WRN_RESET];
	assign alpha_req = drive_control[`DWI_CTL_ALPHA];
	assign ident_req = drive_control[`DWI_CTL_IDENT];
	assign run_req   = drive_control[`DWI_CTL_RUN];
	assign field_req = drive_control[`DWI_CTL_FIELD];

	// ------------------------------------------------------------
	// Field overcurrent persistence
	// ------------------------------------------------------------
	// one second hold
	dwi_persist #(
		.HOLD_CYC (FLDOC_CYC)
	) u_fld_hold (
		.clock (clock),
		.rst_n (rst_n),
		.cond  (field_over_1p5_hot),
		.held  (fld_held)
	);

	// ------------------------------------------------------------
	// Warning set terms
	// ------------------------------------------------------------
	// sync loss avoided
	assign wrn_set[`DWI_WRN_SYNC]  = sync_loss_ridden;
	assign wrn_set[`DWI_WRN_ILIM]  = current_ref_over_limit;
	assign wrn_set[`DWI_WRN_IDENT] = ident_test_failed | resolver_cal_failed;
	assign wrn_set[`DWI_WRN_FLDOC] = fld_held;
	assign wrn_set[`DWI_WRN_AIR]   = airflow_missing;
	assign wrn_set[`DWI_WRN_RAIL]  = rail_error_logged;
	assign wrn_set[`DWI_COMM_CLOCK_DESYNC_FLAG]   = comm_clock_counter_slip;
	assign wrn_set[`DWI_WRN_LINK]  = link_msg_done & link_msg_error;
	assign wrn_set[`DWI_WRN_SHORT] = shorted_test_done & shorted_test_bad;
	assign wrn_set[2:1]  = 2'h0;
	assign wrn_set[11:7] = 5'h00;

	// ------------------------------------------------------------
	// Thyristor map and interlock checks
	// ------------------------------------------------------------
	// pair or single
	always @* begin
		thyr_map = {4'h0, shorted_test_map};
		if (regen_drive) begin
			for (i = 0; i < 6; i = i + 1) begin
				thyr_map[i]     = shorted_test_map[i] |
					shorted_test_map[i + 6];
				thyr_map[i + 6] = shorted_test_map[i] |
					shorted_test_map[i + 6];
			end
		end
	end

	always @* begin
		ilk_next = 16'h0000;
		if ((alpha_req & ident_req) | (alpha_req & run_req) |
			(ident_req & run_req) | (cmd_rise[`DWI_CTL_RUN] & ~task_running) |
			((|cmd_rise) & (|armed_reg)))
			ilk_next[`DWI_ILK_CONFLICT] = 1'b1;
		else if (!arm_params_loaded)
			ilk_next[`DWI_ILK_PARAMS] = 1'b1;
		else if (arm_gains_zero)
			ilk_next[`DWI_ILK_GAINS] = 1'b1;
		else if (arm_faults_pending)
			ilk_next[`DWI_ILK_FAULTS] = 1'b1;
		else if (!run_permissive)
			ilk_next[`DWI_ILK_PERMIT] = 1'b1;
		else if (run_req & ~field_on)
			ilk_next[`DWI_ILK_FNR] = 1'b1;
		else if (field_req & test_running)
			ilk_next[`DWI_ILK_FNA] = 1'b1;
	end

	// ------------------------------------------------------------
	// Latched status
	// ------------------------------------------------------------
	always @(posedge clock) begin
		if (!rst_n) begin
			ctl_prev_reg               <= `DWI_RST_WORD;
			link_err_prev_reg          <= 1'b0;
			armed_reg                  <= 8'h00;
			drive_warning_flags        <= `DWI_RST_WORD;
			thyristor_diagnostic_flags <= `DWI_RST_WORD;
			run_interlock_flags        <= `DWI_RST_WORD;
			link_comm_fault            <= 1'b0;
			shorted_test_start         <= 1'b0;
			current_loop_enable        <= 1'b0;
			field_loop_enable          <= 1'b0;
		end else begin
			ctl_prev_reg <= drive_control;
			// a command stays armed until software drops it
			armed_reg <= (armed_reg | cmd_rise) & drive_control[7:0];
			// latch; set wins over the reset edge
			drive_warning_flags <= (wrn_reset_fall ? 16'h0000 :
				drive_warning_flags) | wrn_set;
			// clear on either reset turned on
			if (shorted_test_done & shorted_test_bad)
				thyristor_diagnostic_flags <= thyr_map;
			else if (flt_reset_on | wrn_reset_on)
				thyristor_diagnostic_flags <= 16'h0000;
			// checks on command rise; only if nothing latched
			if ((|cmd_rise) && (run_interlock_flags == 16'h0000))
				run_interlock_flags <= ilk_next;
			else if (wrn_reset_fall)
				run_interlock_flags <= 16'h0000;
			// Clear first so a fault in the same cycle wins
			if (flt_reset_on)
				link_comm_fault <= 1'b0;
			if (link_msg_done) begin
				link_err_prev_reg <= link_msg_error;
				if (link_msg_error & link_err_prev_reg)
					link_comm_fault <= 1'b1;
			end
			shorted_test_start <= cmd_rise[`DWI_CTL_RUN];
			// loops held off while any interlock set
			current_loop_enable <= run_req & ~(|run_interlock_flags) &
				~(|ilk_next & |cmd_rise);
			field_loop_enable <= field_req & ~(|run_interlock_flags) &
				~(|ilk_next & |cmd_rise);
		end
	end

	// ------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------
	// writes ignored, reads side-effect free
	always @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
			reg_hit   <= 1'b0;
		end else begin
			reg_hit   <= 1'b0;
			reg_rdata <= 16'h0000;
			if (reg_rd) begin
				case (reg_addr)
				`DWI_OFS_WARN: begin
					reg_rdata <= drive_warning_flags;
					reg_hit   <= 1'b1;
				end
				`DWI_OFS_THYR: begin
					reg_rdata <= thyristor_diagnostic_flags;
					reg_hit   <= 1'b1;
				end
				`DWI_OFS_ILK: begin
					reg_rdata <= run_interlock_flags;
					reg_hit   <= 1'b1;
				end
				default: begin
					reg_rdata <= 16'h0000;
				end
				endcase
			end
		end
	end
endmodule // dwi_status

// *** bench/dwi_chk_assertions.sv ***
// Port assertions for the status registers
`timescale 1ns/10ps
module dwi_chk (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [15:0] drive_control,
	input wire logic        link_msg_done,
	input wire logic        link_msg_error,
	input wire logic        shorted_test_done,
	input wire logic        shorted_test_bad,
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_rd,
	input wire logic        reg_hit,
	input wire logic [15:0] drive_warning_flags,
	input wire logic [15:0] thyristor_diagnostic_flags,
	input wire logic [15:0] run_interlock_flags,
	input wire logic        link_comm_fault,
	input wire logic        current_loop_enable,
	input wire logic        field_loop_enable
);
	wire map_hit = (reg_addr >= 8'hcb) && (reg_addr <= 8'hcd);
	wire load    = shorted_test_done && shorted_test_bad;
	wire [15:0] wf = drive_warning_flags;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	// ----------
	// Properties
	// ----------
	property p_rd_hit; reg_rd && map_hit |=> reg_hit; endproperty
	a_rd_hit: assert property (p_rd_hit) else $error("no hit");
	property p_unmapped; reg_rd && !map_hit |=> !reg_hit; endproperty
	a_unmapped: assert property (p_unmapped) else $error("hit");
	property p_wrn_hold;
		!$fell(drive_control[9]) |=> (wf & $past(wf)) == $past(wf);
	endproperty
	a_wrn_hold: assert property (p_wrn_hold) else $error("lost");
	property p_link_fault;
		$rose(link_comm_fault) |-> $past(link_msg_done && link_msg_error);
	endproperty
	a_link_fault: assert property (p_link_fault) else $error("fault");
	property p_first_only; $onehot0(run_interlock_flags); endproperty
	a_first_only: assert property (p_first_only) else $error("two");
	property p_loops_held;
		run_interlock_flags != 16'h0000 |=> !current_loop_enable &&
			!field_loop_enable;
	endproperty
	a_loops_held: assert property (p_loops_held) else $error("ran");
	property p_thyr_clr;
		($rose(drive_control[8]) || $rose(drive_control[9])) && !load
			|=> thyristor_diagnostic_flags == 16'h0000;
	endproperty
	a_thyr_clr: assert property (p_thyr_clr) else $error("kept");
	property p_short_warn; load |=> drive_warning_flags[0]; endproperty
	a_short_warn: assert property (p_short_warn) else $error("bit0");
	c_read: cover property (reg_rd ##1 reg_hit);
	c_fault: cover property ($rose(link_comm_fault));
	c_run: cover property ($rose(current_loop_enable));
endmodule // dwi_chk
bind dwi_status dwi_chk u_chk (.clock, .rst_n, .drive_control,
	.link_msg_done, .link_msg_error, .shorted_test_done, .shorted_test_bad,
	.reg_addr, .reg_rd, .reg_hit, .drive_warning_flags,
	.thyristor_diagnostic_flags, .run_interlock_flags, .link_comm_fault,
	.current_loop_enable, .field_loop_enable);

// *** bench/dwi_pmp_model.sv ***
// Power module processor stand-in
`timescale 1ns/10ps
module dwi_pmp_model (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        shorted_test_start,
	input  wire [3:0]  lat,
	input  wire [11:0] fault_map,
	input  wire        link_err,
	output reg         shorted_test_done,
	output wire        shorted_test_bad,
	output wire [11:0] shorted_test_map,
	output wire        link_msg_done,
	output wire        link_msg_error
);
	reg [4:0] cnt_reg;
	reg [1:0] gap_reg;
	assign link_msg_done  = (gap_reg == 2'h3);
	assign link_msg_error = link_msg_done & link_err;
	assign shorted_test_bad = shorted_test_done && (fault_map != 12'h000);
	// Inverted off-strobe so a stale map is never mistaken
	assign shorted_test_map = shorted_test_done ? fault_map : ~fault_map;
	always @(posedge clock) begin
		gap_reg           <= rst_n ? gap_reg + 2'h1 : 2'h0;
		shorted_test_done <= rst_n && (cnt_reg == 5'h01);
		if (!rst_n || shorted_test_start)
			cnt_reg <= rst_n ? {1'b0, lat} + 5'h02 : 5'h00;
		else if (cnt_reg != 5'h00)
			cnt_reg <= cnt_reg - 5'h01;
	end
endmodule // dwi_pmp_model

// *** bench/drive_warning_interlock_status_tb.sv ***
// Self-checking bench for the drive status registers
`timescale 1ns/10ps
`include "dwi_defs.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
	n_mismatch++; $display("MISMATCH %0t %h vs %h", $time, a, b); end end
module drive_warning_interlock_status_tb;
	logic        clock, rst_n, reg_rd, reg_wr, regen_drive, link_err;
	logic        field_over_1p5_hot, link_msg_done, link_msg_error, reg_hit;
	logic        shorted_test_done, shorted_test_bad, shorted_test_start;
	logic        link_comm_fault, current_loop_enable, field_loop_enable;
	logic [3:0]  lat;
	logic [6:0]  wset, cond;
	logic [7:0]  reg_addr;
	logic [11:0] shorted_test_map, fault_map;
	logic [15:0] drive_control, reg_wdata, reg_rdata, drive_warning_flags;
	logic [15:0] thyristor_diagnostic_flags, run_interlock_flags;
	integer      n_mismatch, samples_checked, k, b, r, exp_w, exp_t;
	integer      wb [0:6] = '{3, 4, 5, 5, 12, 13, 14};
	always #25 clock = ~clock;
	dwi_status #(.FLDOC_CYC(8)) DUT (.clock, .rst_n, .drive_control,
		.sync_loss_ridden(wset[0]), .current_ref_over_limit(wset[1]),
		.ident_test_failed(wset[2]), .resolver_cal_failed(wset[3]),
		.field_over_1p5_hot, .airflow_missing(wset[4]),
		.rail_error_logged(wset[5]), .comm_clock_counter_slip(wset[6]),
		.link_msg_done, .link_msg_error, .shorted_test_done,
		.shorted_test_bad, .shorted_test_map, .regen_drive,
		.task_running(!cond[0]), .arm_params_loaded(!cond[1]),
		.arm_gains_zero(cond[2]), .arm_faults_pending(cond[3]),
		.run_permissive(!cond[4]), .field_on(!cond[5]),
		.test_running(cond[6]), .reg_addr, .reg_rd, .reg_wr, .reg_wdata,
		.reg_rdata, .reg_hit, .drive_warning_flags,
		.thyristor_diagnostic_flags, .run_interlock_flags,
		.link_comm_fault, .shorted_test_start, .current_loop_enable,
		.field_loop_enable);
	dwi_pmp_model PMP (.clock, .rst_n, .shorted_test_start, .lat,
		.fault_map, .link_err, .shorted_test_done, .shorted_test_bad,
		.shorted_test_map, .link_msg_done, .link_msg_error);
	// -----
	// Tasks
	// -----
	task automatic cyc(input integer n);
		repeat (n) @(posedge clock);
	endtask
	task automatic ctl(input [15:0] v);
		@(posedge clock);
		drive_control <= v;
	endtask
	task automatic wres();
		ctl(16'h0200);
		ctl(16'h0000);
	endtask
	task automatic link(input integer n);
		@(posedge clock);
		link_err <= 1'b1;
		cyc(n);
		link_err <= 1'b0;
		cyc(2);
	endtask
	task automatic rd(input [7:0] a, input [15:0] e, input h);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_hit, h)
		`CHK(reg_rdata, e)
	endtask
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#(50 * 5000);
		n_mismatch++;
		give_verdict();
	end
	initial begin
		{clock, rst_n, reg_rd, reg_wr, regen_drive, link_err} = 6'h00;
		{field_over_1p5_hot, wset, cond, lat, reg_addr, fault_map} = 39'h0;
		{drive_control, reg_wdata, n_mismatch, samples_checked} = 0;
		r = $urandom(42);
		cyc(4);
		rst_n <= 1'b1;
		cyc(2);
		rd(`DWI_OFS_WARN, 16'h0000, 1'b1);
		rd(`DWI_OFS_THYR, 16'h0000, 1'b1);
		rd(`DWI_OFS_ILK, 16'h0000, 1'b1);
		rd(8'hce, 16'h0000, 1'b0);
		exp_w = 0;
		for (k = 0; k < 4; k++) begin
			r = $urandom % 128;
			@(posedge clock);
			wset <= r[6:0];
			field_over_1p5_hot <= 1'b1;
			@(posedge clock);
			wset <= 7'h00;
			for (b = 0; b < 7; b++)
				if (r[b]) exp_w[wb[b]] = 1'b1;
			// field overcurrent held 8 edges by the third read
			if (k >= 2) exp_w[`DWI_WRN_FLDOC] = 1'b1;
			reg_wdata <= 16'($urandom);
			reg_wr    <= 1'b1;
			rd(`DWI_OFS_WARN, exp_w[15:0], 1'b1);
			reg_wr <= 1'b0;
		end
		ctl(16'h0200);
		field_over_1p5_hot <= 1'b0;
		rd(`DWI_OFS_WARN, exp_w[15:0], 1'b1);
		ctl(16'h0000);
		rd(`DWI_OFS_WARN, 16'h0000, 1'b1);
		link(4);
		rd(`DWI_OFS_WARN, 16'h8000, 1'b1);
		`CHK(link_comm_fault, 1'b0)
		link(8);
		`CHK(link_comm_fault, 1'b1)
		ctl(16'h0100);
		wres();
		for (k = 0; k < 2; k++) begin
			@(posedge clock);
			regen_drive <= k[0];
			fault_map   <= 12'($urandom % 4095 + 1);
			lat         <= 4'($urandom);
			ctl(16'h0004);
			cyc(20);
			`CHK(current_loop_enable, 1'b1)
			exp_t = k ? {2{fault_map[5:0] | fault_map[11:6]}} : fault_map;
			rd(`DWI_OFS_THYR, exp_t[15:0], 1'b1);
			rd(`DWI_OFS_WARN, 16'h0001, 1'b1);
			ctl(16'h0100);
			ctl(16'h0000);
			rd(`DWI_OFS_THYR, 16'h0000, 1'b1);
			wres();
		end
		for (k = 0; k < 7; k++) begin
			@(posedge clock);
			cond <= (k == 6) ? 7'h40 : (7'h03 << k) & 7'h3f;
			ctl((k == 6) ? 16'h0010 : 16'h0004);
			cyc(2);
			`CHK(current_loop_enable | field_loop_enable, 1'b0)
			rd(`DWI_OFS_ILK, 16'h0001 << k, 1'b1);
			ctl(16'h0000);
			cond <= 7'h00;
			wres();
			rd(`DWI_OFS_ILK, 16'h0000, 1'b1);
		end
		ctl(16'h0001);
		ctl(16'h0005);
		cyc(2);
		rd(`DWI_OFS_ILK, 16'h0001, 1'b1);
		ctl(16'h0000);
		wres();
		ctl(16'h0010);
		cyc(2);
		`CHK(field_loop_enable, 1'b1)
		ctl(16'h0014);
		cyc(2);
		rd(`DWI_OFS_ILK, 16'h0001, 1'b1);
		`CHK(field_loop_enable, 1'b0)
		give_verdict();
	end
endmodule // drive_warning_interlock_status_tb
